// *** hdl/core_bank_pkg.sv ***
// constants shared by the core bank go and sequence control
package core_bank_pkg;
	localparam int ADDR_W       = 17;
	localparam int WORD_ADDR_W  = 12;
	localparam int BANK_CODE_W  = 5;
	localparam int CHASSIS_W    = 3;
	localparam int BANK_SEL_W   = 2;
	localparam int NUM_BANKS    = 4;
	localparam int MODULE_W     = 12;
	localparam int NUM_MODULES  = 5;
	localparam int WORD_W       = 60;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MINOR_CYCLE_NS = 100;
	localparam int STEP_NS       = 50;
	localparam int CYCLE_NS      = 1000;
	localparam int STAGE_HOLD_NS = 400;
	localparam int ACCEPT_LAG_NS = 200;
	localparam int STEP_CYC      = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_CYC     = CYCLE_NS / CLK_PERIOD_NS;
	localparam int STAGE_HOLD_CYC = STAGE_HOLD_NS / CLK_PERIOD_NS;
	localparam int ACCEPT_LAG_CYC = ACCEPT_LAG_NS / CLK_PERIOD_NS;
	localparam int MINOR_CYC     = MINOR_CYCLE_NS / CLK_PERIOD_NS;
	// chain length: pulse walks the chain, the last stage clears at cycle end
	localparam int CHAIN_LEN     = CYCLE_CYC - STAGE_HOLD_CYC + 1;
	localparam int STROBE_NS      = 75;
	localparam int READ_ON_LEAD_NS = 255;
	localparam int READ_LEN_NS    = 395;
	localparam int WRITE_LEN_NS   = 355;
	// stage indices of the timing decode (chain position = cycle number)
	localparam int READ_ON_STG   = 0;
	// durations round to the nearest 50 ns step, which keeps them inside their tolerance
	localparam int HALF_STEP_NS  = CLK_PERIOD_NS / 2;
	localparam int READ_OFF_STG  = READ_ON_STG + (READ_LEN_NS + HALF_STEP_NS) / CLK_PERIOD_NS;
	localparam int STROBE_STG    = READ_ON_STG + (READ_ON_LEAD_NS + HALF_STEP_NS) / CLK_PERIOD_NS;
	localparam int MERGE_STG     = STROBE_STG + 1;
	localparam int INHIBIT_ON_STG = MERGE_STG + 2;
	localparam int WRITE_ON_STG  = INHIBIT_ON_STG + 1;
	localparam int WRITE_OFF_STG = WRITE_ON_STG + (WRITE_LEN_NS + HALF_STEP_NS) / CLK_PERIOD_NS;
	localparam int INHIBIT_OFF_STG = WRITE_OFF_STG + 1;
	localparam int MID_STG       = CHAIN_LEN / 2;
endpackage : core_bank_pkg

// *** hdl/bank_timing_chain.sv ***
// one bank's storage timing chain and drive decode
`timescale 1ns/10ps
module bank_timing_chain
	import core_bank_pkg::*;
(
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_b_in,
	// start
	input  wire logic go_in,
	// status and drives
	output logic      free_out,
	output logic      read_drv_out,
	output logic      sense_out,
	output logic      merge_out,
	output logic      inhibit_out,
	output logic      write_drv_out,
	output logic      store_pt_out
);
	import core_bank_pkg::*;
	typedef struct packed {
		logic [CYCLE_CYC-1:0] pos;
	} chain_st_t;
	chain_st_t st_q, st_d;
	logic [CHAIN_LEN-1:0] stage;
	always_comb begin
		st_d = st_q;
		st_d.pos = {st_q.pos[CYCLE_CYC-2:0], go_in & free_out}; // RULE_17
	end
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0; // RULE_23
		end else begin
			st_q <= st_d;
		end
	end
	// stage i is set from the step the pulse reaches it for the hold time after
	genvar i;
	generate
		for (i = 0; i < CHAIN_LEN; i++) begin : g_stage
			localparam int HI = i + STAGE_HOLD_CYC - 1;
			assign stage[i] = |st_q.pos[HI:i]; // RULE_17
		end
	endgenerate
	// read, middle and last stage overlap so busy holds for the whole transit
	assign free_out      = ~(stage[0] | stage[MID_STG] | stage[CHAIN_LEN-1]); // RULE_18 RULE_19
	assign read_drv_out  = |st_q.pos[READ_OFF_STG-1:READ_ON_STG]; // RULE_16 RULE_20 RULE_21
	assign sense_out     = st_q.pos[STROBE_STG]; // RULE_16 RULE_20
	assign merge_out     = st_q.pos[MERGE_STG]; // RULE_16
	assign inhibit_out   = |st_q.pos[INHIBIT_OFF_STG:INHIBIT_ON_STG]; // RULE_16
	assign write_drv_out = |st_q.pos[WRITE_OFF_STG-1:WRITE_ON_STG]; // RULE_16 RULE_21
	assign store_pt_out  = st_q.pos[WRITE_ON_STG-1]; // RULE_06
	AST_FREE_DROPS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(go_in && free_out) |=> !free_out [*8]) else $error("bank not busy after go"); // RULE_19
	AST_CYCLE_LEN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(go_in && free_out) |-> ##20 !free_out ##1 free_out) else $error("bank not free after cycle"); // RULE_18
endmodule : bank_timing_chain

// *** hdl/core_bank_go_sequence_control.sv ***
// go control, bank select, accept and data paths of one four-bank core chassis
// Function
// RULE_01: four banks run independently, each may start in successive 100 ns slots.
// RULE_02: capture 17-bit address, route 12-bit word address to selected bank register.
// RULE_03: different-bank addresses accepted every minor cycle, one word per minor cycle.
// RULE_04: banks never share a cycle segment; starts are a minor cycle apart. The code lets banks start on successive 50 ns clocks.
// RULE_05: read word goes via temp register to distributor, restore via buffer and write register.
// RULE_06: write word enters temp register, only bank at storing point stores it.
// RULE_07: write qualifier separates reads from writes and steers restore data.
// RULE_08: bank word is five 12-bit modules driven in parallel.
// RULE_09: busy selected bank gives no accept and address is dropped.
// RULE_10: accept returns 200 ns after issue; issuer reissues until accepted.
// RULE_11: on go decode low five bits: three chassis bits, two bank bits.
// RULE_12: chassis bits preset to complement of own code; only a match opens go.
// RULE_13: bank bits set one of four flip-flops with match, free and clock; raise accept.
// RULE_14: issuer drops saved address and sends tags on accept.
// RULE_15: one accept line per chassis, ORed outside, one per 100 ns, 200 ns lag. The code can raise accept on successive 50 ns clocks.
// RULE_16: sequence control presents address and times read, sense, inhibit, merge, write.
// RULE_17: go sets read stage; pulse steps each 50 ns, each stage set 400 ns.
// RULE_18: free only when read, middle and last stages all clear.
// RULE_19: go while free sets read stage and removes free at once.
// RULE_20: strobe at 75 ns, read on 255 ns before the strobe.
// RULE_21: read drive lasts 395 ns, write drive 355 ns.
// RULE_22: on write, clear restore register after merge, then load write word.
// RULE_23: reset clears chains and bank selects; all free and no accept.
`timescale 1ns/10ps
module core_bank_go_sequence_control
	import core_bank_pkg::*;
#(
	parameter logic [CHASSIS_W-1:0] CHASSIS_CODE = 3'h0
)(
	// clock and reset
	input  wire logic                   mclk_in,
	input  wire logic                   rst_b_in,
	// address issue
	input  wire logic [ADDR_W-1:0]      addr_in,
	input  wire logic                   go_in,
	input  wire logic                   write_in,
	output logic                        accept_out,
	// data distributor
	input  wire logic [WORD_W-1:0]      dist_word_in,
	output logic [WORD_W-1:0]           read_word_out,
	output logic                        read_valid_out,
	// storage modules
	input  wire logic [WORD_W-1:0]      sense_word_in,
	output logic [NUM_BANKS*WORD_ADDR_W-1:0] bank_addr_out,
	output logic [NUM_BANKS-1:0]        read_drv_out,
	output logic [NUM_BANKS-1:0]        sense_out,
	output logic [NUM_BANKS-1:0]        inhibit_out,
	output logic [NUM_BANKS-1:0]        write_drv_out,
	output logic [WORD_W-1:0]           restore_word_out,
	output logic [NUM_BANKS-1:0]        bank_free_out
);
	import core_bank_pkg::*;
	localparam int LAG_STAGES = ACCEPT_LAG_CYC - 1;
	if (WORD_W != MODULE_W * NUM_MODULES) begin : g_chk_word
		$error("word width must equal module count times width"); // RULE_08
	end
	if (LAG_STAGES < 2) begin : g_chk_lag
		$error("accept lag too short");
	end
	typedef struct packed {
		logic [ADDR_W-1:0]                 in_addr;
		logic                              in_go;
		logic                              in_write;
		logic [CHASSIS_W-1:0]              chas_sel;
		logic [NUM_BANKS-1:0]              bank_ff;
		logic [NUM_BANKS-1:0][WORD_ADDR_W-1:0] sar;
		logic [NUM_BANKS-1:0]              bank_wr;
		logic [LAG_STAGES-1:0]             acc_pipe;
		logic [WORD_W-1:0]                 temp_reg;
		logic [WORD_W-1:0]                 buf_reg;
		logic [WORD_W-1:0]                 wr_reg;
		logic                              rd_valid;
		logic                              merge_wr;
	} go_st_t;
	go_st_t st_q, st_d;
	logic [NUM_BANKS-1:0] free, merge, store_pt, go_bank;
	logic [NUM_BANKS-1:0] rd_drv, sns, inh, wr_drv;
	logic chassis_match;
	logic [BANK_SEL_W-1:0] bank_code;
	logic any_merge, any_merge_wr;
	function automatic logic [NUM_BANKS-1:0] one_of_four(input logic [BANK_SEL_W-1:0] code);
		one_of_four = '0;
		one_of_four[code] = 1'b1;
	endfunction : one_of_four
	// stored chassis bits sit at the complement until an address arrives with go
	assign chassis_match = st_q.in_go && (st_q.chas_sel == CHASSIS_CODE); // RULE_12 RULE_11
	assign bank_code = st_q.in_addr[BANK_SEL_W-1:0]; // RULE_11
	// a bank whose go is still on its way to the chain reads free for one more edge
	assign go_bank = (chassis_match ? one_of_four(bank_code) : '0) & free & ~st_q.bank_ff; // RULE_13 RULE_09
	assign any_merge = |merge;
	assign any_merge_wr = |(merge & st_q.bank_wr);
	always_comb begin
		st_d = st_q;
		// input register latches every offered address; presets the chassis bits between go
		st_d.in_addr = addr_in; // RULE_02
		st_d.in_go = go_in;
		st_d.in_write = write_in;
		st_d.chas_sel = go_in ? addr_in[BANK_CODE_W-1:BANK_SEL_W] : ~CHASSIS_CODE; // RULE_12
		st_d.bank_ff = go_bank; // RULE_13
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (go_bank[b]) begin
				st_d.sar[b] = st_q.in_addr[ADDR_W-1:ADDR_W-WORD_ADDR_W]; // RULE_02 RULE_16
				st_d.bank_wr[b] = st_q.in_write; // RULE_07
			end
		end
		st_d.acc_pipe = {st_q.acc_pipe[LAG_STAGES-2:0], |go_bank}; // RULE_10 RULE_15
		st_d.rd_valid = 1'b0;
		// only the merging bank's own write flag steers; older writes elsewhere must not
		st_d.merge_wr = any_merge_wr; // RULE_07
		if (any_merge) begin
			st_d.temp_reg = sense_word_in; // RULE_05
			st_d.rd_valid = 1'b1;
		end else if (st_q.merge_wr) begin
			st_d.temp_reg = dist_word_in; // RULE_06
		end
		// write references swap the read word for the distributor word after merge
		st_d.buf_reg = st_q.temp_reg; // RULE_05
		if (st_q.merge_wr) begin
			st_d.buf_reg = dist_word_in; // RULE_22 RULE_07
		end
		st_d.wr_reg = st_q.buf_reg; // RULE_05
	end
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0; // RULE_23
		end else begin
			st_q <= st_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : g_bank
			bank_timing_chain bank_timing_chain_inst (
				.mclk_in       (mclk_in),
				.rst_b_in      (rst_b_in),
				.go_in         (st_q.bank_ff[g]),
				.free_out      (free[g]),
				.read_drv_out  (rd_drv[g]),
				.sense_out     (sns[g]),
				.merge_out     (merge[g]),
				.inhibit_out   (inh[g]),
				.write_drv_out (wr_drv[g]),
				.store_pt_out  (store_pt[g])
			); // RULE_01 RULE_04
			assign bank_addr_out[g*WORD_ADDR_W +: WORD_ADDR_W] = st_q.sar[g]; // RULE_16 RULE_08
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////////
	assign accept_out       = st_q.acc_pipe[LAG_STAGES-1]; // RULE_15 RULE_10
	assign read_word_out    = st_q.temp_reg;
	assign read_valid_out   = st_q.rd_valid; // RULE_03
	assign restore_word_out = st_q.wr_reg; // RULE_05
	assign read_drv_out     = rd_drv;
	assign sense_out        = sns;
	assign inhibit_out      = inh;
	assign write_drv_out    = wr_drv;
	assign bank_free_out    = free;
	////////////////////////////////////////////////////////////////////////////////
	AST_ACCEPT_LAG: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(go_in && addr_in[BANK_CODE_W-1:BANK_SEL_W] == CHASSIS_CODE) ##1 (go_bank != '0)
		|-> ##3 accept_out) else $error("accept missing 200 ns after issue"); // RULE_10
	AST_NO_ACC_OTHER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(go_in && addr_in[BANK_CODE_W-1:BANK_SEL_W] != CHASSIS_CODE) |-> ##4 !accept_out)
		else $error("accept for foreign chassis"); // RULE_12
	AST_BUSY_REFUSE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		!(|(st_q.bank_ff & ~free))) else $error("busy bank started"); // RULE_09
	AST_ONE_BANK_FF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$onehot0(st_q.bank_ff)) else $error("more than one bank flip-flop set"); // RULE_13
	AST_SEG_UNIQUE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$onehot0(sns)) else $error("two banks strobe together"); // RULE_04
	AST_READ_LEN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(rd_drv[0]) |-> rd_drv[0] [*8] ##1 !rd_drv[0]) else $error("read drive length wrong"); // RULE_21
	AST_STROBE_POS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(rd_drv[0]) |-> ##5 sns[0]) else $error("strobe not at read start plus 250 ns"); // RULE_20
	AST_STORE_WRITE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		store_pt[0] |=> $rose(wr_drv[0])) else $error("write drive not after store point"); // RULE_06
	AST_INHIBIT_WRITE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		wr_drv[0] |-> inh[0]) else $error("write drive without inhibit"); // RULE_16
	AST_WRITE_LEN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(wr_drv[0]) |-> wr_drv[0] [*7] ##1 !wr_drv[0]) else $error("write drive length wrong"); // RULE_21
	AST_SAR_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		go_bank[0] |=> st_q.sar[0] == $past(st_q.in_addr[ADDR_W-1:ADDR_W-WORD_ADDR_W]))
		else $error("storage address not loaded"); // RULE_02
	COV_ACCEPT: cover property (@(posedge mclk_in) disable iff (!rst_b_in) accept_out);
	COV_BACK_TO_BACK: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
		st_q.bank_ff[0] ##2 st_q.bank_ff[1]);
	COV_BUSY: cover property (@(posedge mclk_in) disable iff (!rst_b_in) chassis_match && go_bank == '0);
	COV_WRITE: cover property (@(posedge mclk_in) disable iff (!rst_b_in) any_merge_wr);
endmodule : core_bank_go_sequence_control

// *** sim/issuer_model.sv ***
// model of the address issuing unit: hopper, one issue a clock, reissue until accepted or max_tries is reached
`timescale 1ns/10ps
module issuer_model
	import core_bank_pkg::*;
(
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_b_in,
	// issue side
	input  wire logic         accept_in,
	output logic [ADDR_W-1:0] addr_out,
	output logic              go_out,
	output logic              write_out
);
	typedef struct {logic [ADDR_W-1:0] a; logic w; int tries;} ref_t;
	// the accept for an issue is sampled five edges after it is driven
	localparam int DEPTH = ACCEPT_LAG_CYC + 1;
	ref_t       hopper[$];
	ref_t       pend[DEPTH];
	logic [DEPTH-1:0] live = '0;
	int         accepted = 0;
	int         lost = 0;
	int         issues = 0;
	int         stray = 0;
	// a foreign chassis never answers, so give up after the worst-case wait
	int         max_tries = 40;
	initial begin
		addr_out = '0;
		go_out = 1'b0;
		write_out = 1'b0;
	end
	task automatic push(input logic [ADDR_W-1:0] a, input logic w);
		ref_t r;
		r.a = a;
		r.w = w;
		r.tries = 0;
		hopper.push_back(r);
	endtask : push
	always @(posedge mclk_in) begin
		if (live[DEPTH-1]) begin
			if (accept_in === 1'b1) accepted++;
			else if (pend[DEPTH-1].tries >= max_tries) lost++;
			else hopper.push_back(pend[DEPTH-1]);
		end else if (rst_b_in && accept_in !== 1'b0) stray++;
		for (int i = DEPTH-1; i > 0; i--) pend[i] = pend[i-1];
		live = {live[DEPTH-2:0], 1'b0};
		if (hopper.size() > 0) begin
			pend[0] = hopper.pop_front();
			pend[0].tries++;
			live[0] = 1'b1;
			issues++;
			addr_out <= pend[0].a;
			write_out <= pend[0].w;
			go_out <= 1'b1;
		end else begin
			// released lines do not keep the last address
			go_out <= 1'b0;
			addr_out <= ~addr_out;
			write_out <= ~write_out;
		end
	end
endmodule : issuer_model

// *** sim/core_bank_go_sequence_control_tb.sv ***
// self-checking bench for the core bank go and sequence control
`timescale 1ns/10ps
module core_bank_go_sequence_control_tb;
	import core_bank_pkg::*;
	logic                          mclk_in;
	logic                          rst_b_in = 1'b0;
	logic [ADDR_W-1:0]             addr;
	logic                          go, wr, accept_out, read_valid_out;
	logic [WORD_W-1:0]             dist_w = '0, sense_w = '0, read_word_out, restore_word_out, rd_seen, rs_seen;
	logic [NUM_BANKS*WORD_ADDR_W-1:0] bank_addr_out;
	logic [NUM_BANKS-1:0]          read_drv_out, sense_out, inhibit_out, write_drv_out, bank_free_out;
	logic [ADDR_W-1:0]             sent[NUM_BANKS];
	int                            fails = 0, check_count = 0, rd_cnt, wr_cnt, acc0, iss0, b;
	int                            sns_cnt, sns_at, inh_bad;
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	issuer_model issuer_model_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .accept_in(accept_out), .addr_out(addr),
		.go_out(go), .write_out(wr));
	core_bank_go_sequence_control core_bank_go_sequence_control_inst (.mclk_in(mclk_in),
		.rst_b_in(rst_b_in), .addr_in(addr), .go_in(go), .write_in(wr), .accept_out(accept_out),
		.dist_word_in(dist_w), .read_word_out(read_word_out), .read_valid_out(read_valid_out),
		.sense_word_in(sense_w), .bank_addr_out(bank_addr_out), .read_drv_out(read_drv_out),
		.sense_out(sense_out), .inhibit_out(inhibit_out), .write_drv_out(write_drv_out),
		.restore_word_out(restore_word_out), .bank_free_out(bank_free_out));
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge mclk_in) begin
		if (sense_out[0] === 1'b1) sns_at = rd_cnt;
		sns_cnt += int'(sense_out[0]);
		if (write_drv_out[0] === 1'b1 && inhibit_out[0] !== 1'b1) inh_bad++;
		rd_cnt += int'(read_drv_out[0]);
		wr_cnt += int'(write_drv_out[0]);
		if (read_valid_out === 1'b1) rd_seen = read_word_out;
		if (write_drv_out[0] === 1'b1) rs_seen = restore_word_out;
	end
	function automatic logic [ADDR_W-1:0] mk(input logic [CHASSIS_W-1:0] ch, input int bk);
		return {12'($urandom()), ch, 2'(bk)};
	endfunction : mk
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// bounded wait until the hopper and the in-flight issues are empty
	task automatic drain(input int n);
		int k;
		k = 0;
		while ((issuer_model_inst.hopper.size() > 0 || issuer_model_inst.live != 0) && k < n) begin
			@(posedge mclk_in);
			k++;
		end
		if (k >= n) begin
			fails++;
			$display("MISMATCH at %0t: wait ran out", $time);
			finish_test();
		end
	endtask : drain
	task automatic mark();
		acc0 = issuer_model_inst.accepted;
		iss0 = issuer_model_inst.issues;
		rd_cnt = 0;
		wr_cnt = 0;
		sns_cnt = 0;
		sns_at = -1;
		inh_bad = 0;
	endtask : mark
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(17));
		repeat (20) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		chk(64'(bank_free_out), 64'hF, "free after reset");
		chk(64'(accept_out), 64'h0, "accept after reset");
		$display("test reset done");
		@(posedge mclk_in);
		// four banks back to back in rotation from a random first bank, all taken first time
		mark();
		b = int'($urandom_range(3, 0));
		for (int i = 0; i < NUM_BANKS; i++) begin
			sent[(b+i)%4] = mk(3'h0, (b+i)%4);
			issuer_model_inst.push(sent[(b+i)%4], 1'($urandom()));
		end
		drain(200);
		chk(64'(issuer_model_inst.accepted - acc0), 64'h4, "accepts");
		chk(64'(issuer_model_inst.issues - iss0), 64'h4, "issues");
		for (int i = 0; i < NUM_BANKS; i++)
			chk(64'(bank_addr_out[i*12+:12]), 64'(sent[i][16:5]), "bank address");
		repeat (CYCLE_CYC + 4) @(posedge mclk_in);
		chk(64'(bank_free_out), 64'hF, "free after cycles");
		$display("test interleave done");
		// same bank twice: second refused until the first cycle ends
		mark();
		issuer_model_inst.push(mk(3'h0, 2), 1'b0);
		issuer_model_inst.push(mk(3'h0, 2), 1'b0);
		drain(400);
		chk(64'(issuer_model_inst.accepted - acc0), 64'h2, "busy accepts");
		chk(64'(issuer_model_inst.issues - iss0 > 2), 64'h1, "busy refused");
		repeat (CYCLE_CYC + 4) @(posedge mclk_in);
		$display("test busy done");
		// foreign chassis is never accepted
		mark();
		issuer_model_inst.push(mk(3'h5, 1), 1'b0);
		drain(600);
		chk(64'(issuer_model_inst.accepted - acc0), 64'h0, "foreign accepted");
		chk(64'(bank_free_out), 64'hF, "foreign started bank");
		$display("test foreign done");
		// read then write on bank 0: drive widths and data paths
		for (int w = 0; w < 2; w++) begin
			@(posedge mclk_in);
			sense_w <= WORD_W'({$urandom(), $urandom()});
			dist_w <= WORD_W'({$urandom(), $urandom()});
			mark();
			issuer_model_inst.push(mk(3'h0, 0), 1'(w));
			drain(200);
			chk(64'(bank_free_out[0]), 64'h0, "busy after go");
			repeat (CYCLE_CYC + 4) @(posedge mclk_in);
			chk(64'(rd_cnt), 64'((READ_LEN_NS + HALF_STEP_NS) / CLK_PERIOD_NS), "read drive");
			chk(64'(wr_cnt), 64'((WRITE_LEN_NS + HALF_STEP_NS) / CLK_PERIOD_NS), "write drive");
			chk(64'(sns_cnt), 64'h1, "sense strobes");
			chk(64'(sns_at), 64'((READ_ON_LEAD_NS + HALF_STEP_NS) / CLK_PERIOD_NS), "strobe after read on");
			chk(64'(inh_bad), 64'h0, "write without inhibit");
			chk(64'(rd_seen), 64'(sense_w), "read word");
			chk(64'(rs_seen), 64'(w ? dist_w : sense_w), "restore word");
			$display("test data %0d done", w);
		end
		chk(64'(issuer_model_inst.stray), 64'h0, "accept off time");
		finish_test();
	end
endmodule : core_bank_go_sequence_control_tb
